// ==== dtsfe_fifo.sv ====
// dual-clock sample fifo with gray-coded pointers
`timescale 1ns/1ps
module dtsfe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// write side
	input wire logic wr_clk,
	input wire logic wr_rst,
	input wire logic wr_cen,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	// read side
	input wire logic rd_clk,
	input wire logic rd_rst,
	input wire logic rd_cen,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);
	// depth must be a power of two, at least four
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wbin_q, wgray_q, rg_s1, rg_s2, wbin_d;
	logic [AW:0] rbin_q, rgray_q, wg_s1, wg_s2, rbin_d;
	logic push, pop;

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	// ------------------------------------------------------------
	// write domain
	// ------------------------------------------------------------
	assign wr_ready = wgray_q != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]};
	assign push = wr_valid & wr_ready & wr_cen;
	assign wbin_d = wbin_q + (AW+1)'(1);

	always_ff @(posedge wr_clk) begin
		if (wr_rst) begin
			wbin_q <= '0;
			wgray_q <= '0;
			rg_s1 <= '0;
			rg_s2 <= '0;
		end else if (wr_cen) begin
			rg_s1 <= rgray_q;
			rg_s2 <= rg_s1;
			if (push) begin
				wbin_q <= wbin_d;
				wgray_q <= to_gray(wbin_d);
			end
		end
	end

	always_ff @(posedge wr_clk) begin
		if (push) begin
			mem[wbin_q[AW-1:0]] <= wr_data;
		end
	end

	// ------------------------------------------------------------
	// read domain
	// ------------------------------------------------------------
	assign rd_valid = rgray_q != wg_s2;
	assign pop = rd_valid & rd_ready & rd_cen;
	assign rbin_d = rbin_q + (AW+1)'(1);
	assign rd_data = mem[rbin_q[AW-1:0]];

	always_ff @(posedge rd_clk) begin
		if (rd_rst) begin
			rbin_q <= '0;
			rgray_q <= '0;
			wg_s1 <= '0;
			wg_s2 <= '0;
		end else if (rd_cen) begin
			wg_s1 <= wgray_q;
			wg_s2 <= wg_s1;
			if (pop) begin
				rbin_q <= rbin_d;
				rgray_q <= to_gray(rbin_d);
			end
		end
	end
endmodule

// ==== dtsfe_top.sv ====
// stream timing front end: package and top-level module
`timescale 1ns/1ps
package dtsfe_pkg;
	localparam int NUM_STREAMS = 32;
	localparam int SEC_BITS = 32;
	localparam int CYC_BITS = 28;
	localparam int MON_BITS = 22;
	localparam int FIFO_DEPTH = 16;
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int AUX_BAUD = 115_000;
	localparam int AUX_BIT_CYCLES = SYS_CLK_HZ / AUX_BAUD;
	localparam int AUX_HALF_CYCLES = AUX_BIT_CYCLES / 2;
	localparam int AUX_MAX_BYTES = 2048;
	localparam int BASE_CLK_HZ = 2_000_000;
	localparam int MON_TIME_MS = 10;
	localparam int MON_BASE_CYCLES = BASE_CLK_HZ / 1000 * MON_TIME_MS;
	localparam logic [2:0] RATE_SEL_MAX = 3'h6;
	localparam logic [4:0] SYNC_RESET = 5'h01;

	typedef struct packed {
		logic on_tick;
		logic [SEC_BITS-1:0] sec;
		logic [NUM_STREAMS-1:0] bits;
	} dtsfe_sample_type;

	typedef struct packed {
		logic [2:0] clk_sel;
		logic [2:0] k_sel;
		logic alt_src;
	} dtsfe_samp_cfg_type;

	typedef enum logic [3:0] {
		AUX_IDLE = 4'h1,
		AUX_START = 4'h2,
		AUX_DATA = 4'h4,
		AUX_STOP = 4'h8
	} dtsfe_aux_state_type;

	typedef enum logic [1:0] {
		ARM_IDLE = 2'h1,
		ARM_WAIT = 2'h2
	} dtsfe_arm_state_type;
endpackage

module dtsfe_top import dtsfe_pkg::*; #(
	parameter int TICK_BASE_CYCLES = BASE_CLK_HZ,
	parameter int MON_BASE = MON_BASE_CYCLES
) (
	// processing-side clock and control
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	// acquisition link
	input wire logic samp_clk,
	input wire logic [NUM_STREAMS-1:0] input_bit_stream,
	input wire logic sec_tick,
	input wire logic alternate_sec_tick,
	input wire logic aux_serial_in,
	// sampling control
	input wire logic [2:0] samp_clk_sel,
	input wire logic [2:0] samp_rate_sel,
	input wire logic samp_alt_src,
	input wire logic samp_set_cmd,
	input wire logic [SEC_BITS-1:0] samp_set_sec,
	// sampling status
	output logic sample_time_monitor,
	output logic samp_locked,
	output logic samp_overflow,
	// sample stream
	output logic sample_valid,
	input wire logic sample_ready,
	output dtsfe_sample_type sample_data,
	// aux serial bytes
	output logic aux_byte_valid,
	output logic [7:0] aux_byte,
	output logic aux_overrun,
	// replay timing
	input wire logic processing_sec_tick,
	input wire logic [2:0] proc_clk_sel,
	input wire logic [2:0] replay_rate_sel,
	input wire logic replay_set_cmd,
	input wire logic [SEC_BITS-1:0] replay_set_sec,
	output logic replay_locked,
	output logic [SEC_BITS-1:0] replay_time_sec,
	output logic replay_clock,
	output logic replay_sec_pulse
);
	function automatic logic [2:0] clamp_sel(input logic [2:0] s);
		return (s > RATE_SEL_MAX) ? RATE_SEL_MAX : s;
	endfunction

	// ------------------------------------------------------------
	// sys domain: sampling commands
	// ------------------------------------------------------------
	dtsfe_samp_cfg_type scfg_q;
	logic sset_tgl_q;
	logic [SEC_BITS-1:0] sset_sec_q;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			scfg_q <= '0;
			sset_tgl_q <= 1'b0;
			sset_sec_q <= '0;
		end else if (clk_en) begin
			scfg_q <= '{clamp_sel(samp_clk_sel), clamp_sel(samp_rate_sel),
				samp_alt_src};
			if (samp_set_cmd) begin
				sset_tgl_q <= ~sset_tgl_q;
				sset_sec_q <= samp_set_sec;
			end
		end
	end

	// ------------------------------------------------------------
	// link domain: reset, enable and control crossing
	// ------------------------------------------------------------
	logic lrst_s1, lrst_q, lcen_s1, lcen_q;
	dtsfe_samp_cfg_type lcfg_s1, lcfg_q;
	logic lset_s1, lset_s2, lset_s3;

	// reset and enable themselves must cross unconditionally
	always_ff @(posedge samp_clk) begin
		lrst_s1 <= srst;
		lrst_q <= lrst_s1;
		lcen_s1 <= clk_en;
		lcen_q <= lcen_s1;
	end

	// config is quasi-static; change it only with the counter unset
	always_ff @(posedge samp_clk) begin
		if (lrst_q) begin
			lcfg_s1 <= '0;
			lcfg_q <= '0;
			lset_s1 <= 1'b0;
			lset_s2 <= 1'b0;
			lset_s3 <= 1'b0;
		end else if (lcen_q) begin
			lcfg_s1 <= scfg_q;
			lcfg_q <= lcfg_s1;
			lset_s1 <= sset_tgl_q;
			lset_s2 <= lset_s1;
			lset_s3 <= lset_s2;
		end
	end

	// ------------------------------------------------------------
	// link domain: inputs and tick edges
	// ------------------------------------------------------------
	logic [NUM_STREAMS-1:0] bits_q;
	logic tick_q, tick_prev_q, alt_s1, alt_s2, alt_prev_q;
	logic pri_edge, alt_edge, tick_sel, set_req, set_now;

	always_ff @(posedge samp_clk) begin
		if (lrst_q) begin
			bits_q <= '0;
			tick_q <= 1'b0;
			tick_prev_q <= 1'b0;
			alt_s1 <= 1'b0;
			alt_s2 <= 1'b0;
			alt_prev_q <= 1'b0;
		end else if (lcen_q) begin
			bits_q <= input_bit_stream;
			tick_q <= sec_tick;
			tick_prev_q <= tick_q;
			alt_s1 <= alternate_sec_tick;
			alt_s2 <= alt_s1;
			alt_prev_q <= alt_s2;
		end
	end

	assign pri_edge = tick_q & ~tick_prev_q;
	assign alt_edge = alt_s2 & ~alt_prev_q;
	assign tick_sel = lcfg_q.alt_src ? alt_edge : pri_edge;
	assign set_req = lset_s2 ^ lset_s3;

	// ------------------------------------------------------------
	// link domain: sample time counter and sampling
	// ------------------------------------------------------------
	logic [CYC_BITS-1:0] cyc_q, pos_d, kmask, period_last;
	logic [SEC_BITS-1:0] sec_q, sec_d, set_sec_q;
	logic [2:0] k_eff;
	logic arm_q, locked_q, sample_now, ovf_q, ptick_tgl_q;
	logic wr_valid, wr_ready;
	dtsfe_sample_type wr_data;

	assign set_now = arm_q & tick_sel;
	// info rate never exceeds the clock and never drops below 2 Mbps
	assign k_eff = (lcfg_q.k_sel > lcfg_q.clk_sel) ? lcfg_q.clk_sel
		: lcfg_q.k_sel;
	assign kmask = (CYC_BITS'(1) << k_eff) - CYC_BITS'(1);
	assign period_last = (CYC_BITS'(TICK_BASE_CYCLES) << lcfg_q.clk_sel)
		- CYC_BITS'(1);

	always_comb begin
		if (set_now || cyc_q == period_last) begin
			pos_d = '0;
		end else begin
			pos_d = cyc_q + CYC_BITS'(1);
		end
		if (set_now) begin
			sec_d = set_sec_q;
		end else if (locked_q && pos_d == '0) begin
			sec_d = sec_q + SEC_BITS'(1);
		end else begin
			sec_d = sec_q;
		end
	end

	assign sample_now = (pos_d & kmask) == '0;
	assign wr_valid = sample_now & lcen_q & ~lrst_q;
	assign wr_data = '{set_now | (locked_q & pos_d == '0), sec_d, bits_q};

	always_ff @(posedge samp_clk) begin
		if (lrst_q) begin
			cyc_q <= '0;
			sec_q <= '0;
			set_sec_q <= '0;
			arm_q <= 1'b0;
			locked_q <= 1'b0;
			ovf_q <= 1'b0;
			ptick_tgl_q <= 1'b0;
		end else if (lcen_q) begin
			cyc_q <= pos_d;
			sec_q <= sec_d;
			if (set_req) begin
				arm_q <= 1'b1;
				set_sec_q <= sset_sec_q;
			end else if (set_now) begin
				arm_q <= 1'b0;
			end
			if (set_now) begin
				locked_q <= 1'b1;
			end
			if (wr_valid && !wr_ready) begin
				ovf_q <= 1'b1;
			end
			if (pri_edge) begin
				ptick_tgl_q <= ~ptick_tgl_q;
			end
		end
	end

	// ------------------------------------------------------------
	// link domain: stretched monitor pulse
	// ------------------------------------------------------------
	logic [MON_BITS-1:0] mon_cnt_q;
	logic mon_q;

	always_ff @(posedge samp_clk) begin
		if (lrst_q) begin
			mon_cnt_q <= '0;
			mon_q <= 1'b0;
		end else if (lcen_q) begin
			if (set_now || (locked_q && pos_d == '0)) begin
				mon_cnt_q <= MON_BITS'(MON_BASE) << lcfg_q.clk_sel;
				mon_q <= 1'b1;
			end else if (mon_cnt_q > MON_BITS'(1)) begin
				mon_cnt_q <= mon_cnt_q - MON_BITS'(1);
			end else begin
				mon_cnt_q <= '0;
				mon_q <= 1'b0;
			end
		end
	end

	assign sample_time_monitor = mon_q;

	dtsfe_fifo #(.WIDTH($bits(dtsfe_sample_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.wr_clk(samp_clk),
		.wr_rst(lrst_q),
		.wr_cen(lcen_q),
		.wr_valid(wr_valid),
		.wr_ready(wr_ready),
		.wr_data(wr_data),
		.rd_clk(sys_clk),
		.rd_rst(srst),
		.rd_cen(clk_en),
		.rd_valid(sample_valid),
		.rd_ready(sample_ready),
		.rd_data(sample_data)
	);

	// ------------------------------------------------------------
	// sys domain: status and pin synchronisers
	// ------------------------------------------------------------
	logic [4:0] ss1_q, ss2_q;
	logic ptick_prev_q, ps_prev_q, ptick_ev, proc_edge, rx;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ss1_q <= SYNC_RESET;
			ss2_q <= SYNC_RESET;
			ptick_prev_q <= 1'b0;
			ps_prev_q <= 1'b0;
		end else if (clk_en) begin
			ss1_q <= {locked_q, ovf_q, ptick_tgl_q, processing_sec_tick,
				aux_serial_in};
			ss2_q <= ss1_q;
			ptick_prev_q <= ss2_q[2];
			ps_prev_q <= ss2_q[1];
		end
	end

	assign samp_locked = ss2_q[4];
	assign samp_overflow = ss2_q[3];
	assign ptick_ev = ss2_q[2] ^ ptick_prev_q;
	assign proc_edge = ss2_q[1] & ~ps_prev_q;
	assign rx = ss2_q[0];

	// ------------------------------------------------------------
	// sys domain: aux serial receiver with per-second budget
	// ------------------------------------------------------------
	dtsfe_aux_state_type aux_st_q;
	logic [8:0] aux_cnt_q;
	logic [2:0] aux_idx_q;
	logic [7:0] aux_sh_q;
	logic [11:0] aux_bytes_q;
	logic aux_done;

	assign aux_done = (aux_st_q == AUX_STOP) && aux_cnt_q == '0 && rx;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			aux_st_q <= AUX_IDLE;
			aux_cnt_q <= '0;
			aux_idx_q <= '0;
			aux_sh_q <= '0;
		end else if (clk_en) begin
			case (aux_st_q)
				AUX_IDLE: begin
					aux_cnt_q <= 9'(AUX_HALF_CYCLES);
					if (!rx) aux_st_q <= AUX_START;
				end
				AUX_START: begin
					if (aux_cnt_q != '0) begin
						aux_cnt_q <= aux_cnt_q - 9'h001;
					end else begin
						aux_cnt_q <= 9'(AUX_BIT_CYCLES - 1);
						aux_idx_q <= '0;
						aux_st_q <= rx ? AUX_IDLE : AUX_DATA;
					end
				end
				AUX_DATA: begin
					if (aux_cnt_q != '0) begin
						aux_cnt_q <= aux_cnt_q - 9'h001;
					end else begin
						aux_cnt_q <= 9'(AUX_BIT_CYCLES - 1);
						aux_sh_q <= {rx, aux_sh_q[7:1]};
						aux_idx_q <= aux_idx_q + 3'h1;
						if (aux_idx_q == 3'h7) aux_st_q <= AUX_STOP;
					end
				end
				AUX_STOP: begin
					if (aux_cnt_q != '0) begin
						aux_cnt_q <= aux_cnt_q - 9'h001;
					end else begin
						aux_st_q <= AUX_IDLE;
					end
				end
				default: aux_st_q <= AUX_IDLE;
			endcase
		end
	end

	// bytes past the budget are dropped; the flag survives a same-cycle tick
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			aux_bytes_q <= '0;
			aux_byte_valid <= 1'b0;
			aux_byte <= '0;
			aux_overrun <= 1'b0;
		end else if (clk_en) begin
			aux_byte_valid <= 1'b0;
			if (aux_done && aux_bytes_q < 12'(AUX_MAX_BYTES)) begin
				aux_byte_valid <= 1'b1;
				aux_byte <= aux_sh_q;
			end
			if (ptick_ev) begin
				aux_bytes_q <= aux_done ? 12'h001 : 12'h000;
			end else if (aux_done && aux_bytes_q < 12'(AUX_MAX_BYTES)) begin
				aux_bytes_q <= aux_bytes_q + 12'h001;
			end
			if (aux_done && aux_bytes_q >= 12'(AUX_MAX_BYTES)) begin
				aux_overrun <= 1'b1;
			end else if (ptick_ev) begin
				aux_overrun <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// sys domain: replay time counter
	// ------------------------------------------------------------
	dtsfe_arm_state_type rarm_q;
	logic [CYC_BITS-1:0] rcyc_q, rpos_d, rlast, rmask;
	logic [SEC_BITS-1:0] rset_sec_q;
	logic [2:0] rproc, rrep;
	logic rset_now;

	assign rproc = clamp_sel(proc_clk_sel);
	assign rrep = (clamp_sel(replay_rate_sel) > rproc) ? rproc
		: clamp_sel(replay_rate_sel);
	assign rmask = (CYC_BITS'(1) << (rproc - rrep)) - CYC_BITS'(1);
	assign rlast = (CYC_BITS'(TICK_BASE_CYCLES) << rproc) - CYC_BITS'(1);
	assign rset_now = (rarm_q == ARM_WAIT) && proc_edge;
	assign rpos_d = (rset_now || rcyc_q == rlast) ? '0
		: rcyc_q + CYC_BITS'(1);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rarm_q <= ARM_IDLE;
			rset_sec_q <= '0;
		end else if (clk_en) begin
			case (rarm_q)
				ARM_IDLE: begin
					if (replay_set_cmd) begin
						rarm_q <= ARM_WAIT;
						rset_sec_q <= replay_set_sec;
					end
				end
				ARM_WAIT: begin
					if (replay_set_cmd) begin
						rset_sec_q <= replay_set_sec;
					end else if (proc_edge) begin
						rarm_q <= ARM_IDLE;
					end
				end
				default: rarm_q <= ARM_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rcyc_q <= '0;
			replay_locked <= 1'b0;
			replay_time_sec <= '0;
			replay_clock <= 1'b0;
			replay_sec_pulse <= 1'b0;
		end else if (clk_en) begin
			rcyc_q <= rpos_d;
			if (rset_now) begin
				replay_locked <= 1'b1;
				replay_time_sec <= rset_sec_q;
			end else if (replay_locked && rpos_d == '0) begin
				replay_time_sec <= replay_time_sec + SEC_BITS'(1);
			end
			replay_clock <= (replay_locked | rset_now)
				&& (rpos_d & rmask) == '0;
			replay_sec_pulse <= rset_now | (replay_locked && rpos_d == '0);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_samp_reset;
		@(posedge samp_clk) disable iff (lrst_q)
		$fell(lrst_q) |-> !locked_q && cyc_q == '0 && !arm_q;
	endproperty
	a_samp_reset: assert property (p_samp_reset) else $error("link reset left counter set");

	property p_tick_sets;
		@(posedge samp_clk) disable iff (lrst_q)
		arm_q && tick_sel && lcen_q && !set_req |=>
			cyc_q == '0 && sec_q == $past(set_sec_q) && locked_q && !arm_q;
	endproperty
	a_tick_sets: assert property (p_tick_sets) else $error("commanded tick did not set counter");

	property p_on_tick_sample;
		@(posedge samp_clk) disable iff (lrst_q)
		set_now && lcen_q |-> wr_valid && wr_data.on_tick;
	endproperty
	a_on_tick_sample: assert property (p_on_tick_sample) else $error("on-tick sample missing");

	property p_tick_ignored;
		@(posedge samp_clk) disable iff (lrst_q)
		!arm_q && tick_sel && lcen_q && cyc_q != period_last |=>
			cyc_q == $past(cyc_q) + CYC_BITS'(1);
	endproperty
	a_tick_ignored: assert property (p_tick_ignored) else $error("unarmed tick disturbed counter");

	property p_one_tick;
		@(posedge samp_clk) disable iff (lrst_q)
		pri_edge && lcen_q |=> !pri_edge
			&& ptick_tgl_q != $past(ptick_tgl_q);
	endproperty
	a_one_tick: assert property (p_one_tick) else $error("tick counted twice");

	property p_mon_stretch;
		@(posedge samp_clk) disable iff (lrst_q)
		$rose(sample_time_monitor) |-> sample_time_monitor[*8];
	endproperty
	a_mon_stretch: assert property (p_mon_stretch) else $error("monitor pulse too short");

	property p_mon_start;
		@(posedge samp_clk) disable iff (lrst_q)
		locked_q && pos_d == '0 && lcen_q |=> sample_time_monitor;
	endproperty
	a_mon_start: assert property (p_mon_start) else $error("no monitor pulse at second");

	property p_replay_reset;
		@(posedge sys_clk) disable iff (srst)
		$fell(srst) |-> !replay_locked && rcyc_q == '0 && rarm_q == ARM_IDLE;
	endproperty
	a_replay_reset: assert property (p_replay_reset) else $error("replay counter not reset");

	property p_replay_set;
		@(posedge sys_clk) disable iff (srst)
		rset_now && clk_en |=> replay_locked && rcyc_q == '0
			&& replay_time_sec == $past(rset_sec_q) && replay_sec_pulse;
	endproperty
	a_replay_set: assert property (p_replay_set) else $error("replay epoch not set");

	property p_replay_ignore;
		@(posedge sys_clk) disable iff (srst)
		rarm_q == ARM_IDLE && proc_edge && clk_en && rcyc_q != rlast |=>
			rcyc_q == $past(rcyc_q) + CYC_BITS'(1);
	endproperty
	a_replay_ignore: assert property (p_replay_ignore) else $error("unarmed tick moved replay counter");

	property p_replay_rate;
		@(posedge sys_clk) disable iff (srst)
		replay_clock && clk_en && rproc != rrep |=> !replay_clock;
	endproperty
	a_replay_rate: assert property (p_replay_rate) else $error("replay clock too fast");

	c_samp_set: cover property (@(posedge samp_clk) disable iff (lrst_q) set_now);
	c_fifo_full: cover property (@(posedge samp_clk) disable iff (lrst_q) wr_valid && !wr_ready);
	c_replay_set: cover property (@(posedge sys_clk) disable iff (srst) rset_now);
	c_aux_byte: cover property (@(posedge sys_clk) disable iff (srst) aux_byte_valid);
endmodule

// ==== dtsfe_acq_model.sv ====
// acquisition side model: bit streams, second ticks, aux serial line
`timescale 1ns/1ps
module dtsfe_acq_model import dtsfe_pkg::*; (
	// clocks
	input wire logic samp_clk,
	input wire logic sys_clk,
	// acquisition link
	output logic [NUM_STREAMS-1:0] input_bit_stream,
	output logic sec_tick,
	output logic alternate_sec_tick,
	output logic aux_serial_in
);
	logic [NUM_STREAMS-1:0] tick_bits;
	initial begin
		input_bit_stream = 32'h0000_0000;
		sec_tick = 1'b0;
		alternate_sec_tick = 1'b0;
		aux_serial_in = 1'b1;
		tick_bits = 32'h0000_0000;
	end
	// -----
	// samplers
	// -----
	// a counting pattern makes every clock's bit distinct
	always @(posedge samp_clk) begin
		input_bit_stream <= input_bit_stream + 32'h0000_0001;
	end
	task automatic pulse_tick();
		@(posedge samp_clk);
		tick_bits = input_bit_stream + 32'h0000_0001;
		sec_tick <= 1'b1;
		@(posedge samp_clk);
		sec_tick <= 1'b0;
	endtask
	// off-edge on purpose: this tick owes nothing to the clock
	task automatic pulse_alt();
		@(posedge samp_clk);
		#37;
		alternate_sec_tick = 1'b1;
		repeat (3) @(posedge samp_clk);
		#37;
		alternate_sec_tick = 1'b0;
	endtask
	// -----
	// aux serial
	// -----
	task automatic send_byte(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			aux_serial_in <= f[i];
			repeat (AUX_BIT_CYCLES - 1) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		aux_serial_in <= 1'b1;
	endtask
endmodule

// ==== test_dts_stream_timing_front_end.sv ====
// self-checking bench for the stream timing front end
`timescale 1ns/1ps
module test_dts_stream_timing_front_end import dtsfe_pkg::*;;
	localparam int TB = 64;
	localparam int MB = 10;
	logic sys_clk = 1'b0;
	logic samp_clk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic [2:0] samp_clk_sel = 3'h2;
	logic [2:0] samp_rate_sel = 3'h2;
	logic [2:0] proc_clk_sel = 3'h2;
	logic [2:0] replay_rate_sel = 3'h0;
	logic samp_alt_src = 1'b0;
	logic samp_set_cmd = 1'b0;
	logic [31:0] samp_set_sec = 32'h0000_0000;
	logic sample_ready = 1'b0;
	logic processing_sec_tick = 1'b0;
	logic replay_set_cmd = 1'b0;
	logic [31:0] replay_set_sec = 32'h0000_0000;
	logic [31:0] input_bit_stream;
	logic sec_tick, alternate_sec_tick, aux_serial_in;
	logic sample_time_monitor, samp_locked, samp_overflow, sample_valid;
	dtsfe_sample_type sample_data;
	logic aux_byte_valid, aux_overrun, replay_locked, replay_clock;
	logic replay_sec_pulse;
	logic [7:0] aux_byte;
	logic [31:0] replay_time_sec;
	int err_total = 0;
	int checks = 0;
	always #12.5 sys_clk = ~sys_clk;
	always #80 samp_clk = ~samp_clk;
	dtsfe_top #(.TICK_BASE_CYCLES(TB), .MON_BASE(MB)) i_dut (
		.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
		.samp_clk(samp_clk), .input_bit_stream(input_bit_stream),
		.sec_tick(sec_tick), .alternate_sec_tick(alternate_sec_tick),
		.aux_serial_in(aux_serial_in), .samp_clk_sel(samp_clk_sel),
		.samp_rate_sel(samp_rate_sel), .samp_alt_src(samp_alt_src),
		.samp_set_cmd(samp_set_cmd), .samp_set_sec(samp_set_sec),
		.sample_time_monitor(sample_time_monitor),
		.samp_locked(samp_locked), .samp_overflow(samp_overflow),
		.sample_valid(sample_valid), .sample_ready(sample_ready),
		.sample_data(sample_data), .aux_byte_valid(aux_byte_valid),
		.aux_byte(aux_byte), .aux_overrun(aux_overrun),
		.processing_sec_tick(processing_sec_tick),
		.proc_clk_sel(proc_clk_sel), .replay_rate_sel(replay_rate_sel),
		.replay_set_cmd(replay_set_cmd), .replay_set_sec(replay_set_sec),
		.replay_locked(replay_locked), .replay_time_sec(replay_time_sec),
		.replay_clock(replay_clock), .replay_sec_pulse(replay_sec_pulse));
	dtsfe_acq_model acq (.samp_clk(samp_clk), .sys_clk(sys_clk),
		.input_bit_stream(input_bit_stream), .sec_tick(sec_tick),
		.alternate_sec_tick(alternate_sec_tick),
		.aux_serial_in(aux_serial_in));
	// -----
	// helpers
	// -----
	task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wt(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (s !== 1'b1) begin
			err_total++;
			$display("MISMATCH wait expected 1 seen timeout");
			conclude();
		end
	endtask
	// a source change needs a fresh reset, so reset carries the source
	task automatic do_reset(logic alt);
		@(posedge sys_clk);
		srst <= 1'b1;
		samp_alt_src <= alt;
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (40) @(posedge sys_clk);
		#1;
	endtask
	task automatic arm(logic [31:0] s);
		@(posedge sys_clk);
		samp_set_sec <= s;
		samp_set_cmd <= 1'b1;
		@(posedge sys_clk);
		samp_set_cmd <= 1'b0;
		repeat (40) @(posedge sys_clk);
	endtask
	task automatic pop(output dtsfe_sample_type w);
		wt(sample_valid, 400);
		@(posedge sys_clk);
		sample_ready <= 1'b1;
		@(posedge sys_clk);
		w = sample_data;
		sample_ready <= 1'b0;
		#1;
	endtask
	// skips samples taken before the counter was set
	task automatic seek(output dtsfe_sample_type w);
		int n;
		n = 0;
		do begin
			pop(w);
			n++;
		end while (w.on_tick !== 1'b1 && n < 20);
	endtask
	task automatic ptick();
		@(posedge sys_clk);
		processing_sec_tick <= 1'b1;
		@(posedge sys_clk);
		processing_sec_tick <= 1'b0;
		#1;
	endtask
	// pops one counter second, each sample four clocks after the last
	task automatic second(input dtsfe_sample_type w, input logic [31:0] es);
		logic [31:0] pv;
		int n;
		pv = w.bits;
		n = 0;
		do begin
			pop(w);
			n++;
			chk("bits", pv + 32'h0000_0004, w.bits);
			pv = w.bits;
		end while (w.on_tick !== 1'b1 && n < 80);
		chk("per_second", 8'h40, n);
		chk("next_sec", es, w.sec);
	endtask
	// -----
	// scenarios
	// -----
	task automatic t_primary();
		dtsfe_sample_type w;
		logic [31:0] on_tick_sample;
		arm(32'h0000_0005);
		acq.pulse_tick();
		on_tick_sample = acq.tick_bits;
		wt(samp_locked, 40);
		chk("monitor", 1'b1, sample_time_monitor);
		seek(w);
		chk("on_tick", 1'b1, w.on_tick);
		chk("sec", 32'h0000_0005, w.sec);
		chk("on_tick_sample_bits", on_tick_sample, w.bits);
		fork
			acq.pulse_tick();
			begin
				repeat (300) @(posedge sys_clk);
				#1;
				chk("monitor_end", 1'b0, sample_time_monitor);
			end
			second(w, 32'h0000_0006);
		join
		$display("done primary");
	endtask
	task automatic t_overflow();
		dtsfe_sample_type w;
		int n;
		repeat (800) @(posedge sys_clk);
		#1;
		chk("overflow", 1'b1, samp_overflow);
		chk("full_valid", 1'b1, sample_valid);
		n = 0;
		while (sample_valid === 1'b1 && n < 40) begin
			pop(w);
			n++;
		end
		chk("drained", 1'b0, sample_valid);
		$display("done overflow");
	endtask
	task automatic t_aux();
		int seen;
		fork acq.send_byte(8'ha5, 1'b1); join_none
		wt(aux_byte_valid, 4000);
		chk("aux_byte", 8'ha5, aux_byte);
		chk("aux_overrun", 1'b0, aux_overrun);
		repeat (400) @(posedge sys_clk);
		fork acq.send_byte(8'h3c, 1'b0); join_none
		seen = 0;
		repeat (4000) begin
			@(posedge sys_clk);
			#1;
			seen += (aux_byte_valid === 1'b1);
		end
		chk("bad_stop", 8'h00, seen);
		$display("done aux");
	endtask
	task automatic t_replay();
		int cnt;
		ptick();
		repeat (10) @(posedge sys_clk);
		#1;
		chk("unarmed", 1'b0, replay_locked);
		@(posedge sys_clk);
		replay_set_sec <= 32'h0000_0009;
		replay_set_cmd <= 1'b1;
		@(posedge sys_clk);
		replay_set_cmd <= 1'b0;
		ptick();
		wt(replay_locked, 20);
		chk("rtime", 32'h0000_0009, replay_time_sec);
		chk("rpulse", 1'b1, replay_sec_pulse);
		chk("rclk", 1'b1, replay_clock);
		cnt = 0;
		for (int i = 1; i < 256; i++) begin
			@(posedge sys_clk);
			processing_sec_tick <= (i == 100 || i == 101);
			#1;
			cnt += (replay_clock === 1'b1);
			if (replay_sec_pulse !== 1'b0) chk("early", 1'b0, replay_sec_pulse);
		end
		chk("rclk_count", 8'h3f, cnt);
		@(posedge sys_clk);
		#1;
		chk("rtime_next", 32'h0000_000a, replay_time_sec);
		chk("rpulse_next", 1'b1, replay_sec_pulse);
		$display("done replay");
	endtask
	task automatic t_alt();
		dtsfe_sample_type w;
		do_reset(1'b1);
		acq.pulse_alt();
		repeat (40) @(posedge sys_clk);
		#1;
		chk("alt_unarmed", 1'b0, samp_locked);
		arm(32'h0000_0014);
		acq.pulse_alt();
		wt(samp_locked, 60);
		seek(w);
		chk("alt_on_tick", 1'b1, w.on_tick);
		chk("alt_sec", 32'h0000_0014, w.sec);
		fork acq.pulse_alt(); join_none
		second(w, 32'h0000_0015);
		$display("done alternate");
	endtask
	initial begin
		do_reset(1'b0);
		t_primary();
		t_overflow();
		t_aux();
		t_replay();
		t_alt();
		conclude();
	end
endmodule
